// *** src/sra_pkg.sv ***
/*
  sra_pkg: constants, register map and carrier types of the status record assembler.
  assumes: used by sra_top and sra_packer, referenced only as sra_pkg::name.
*/
package sra_pkg;

  // record layout
  localparam logic [7:0] REC_AXES = 8'h01;
  localparam logic [7:0] REC_HDR_BYTES = 8'h04;
  localparam logic [7:0] REC_GEN_BYTES = 8'h12;
  localparam logic [7:0] REC_PLANE_BYTES = 8'h10;
  localparam logic [7:0] REC_AXIS_BYTES = 8'h24;
  localparam logic [15:0] REC_LEN = 16'h004a;
  localparam int REC_BITS = 592;
  localparam logic [6:0] REC_LAST_IDX = 7'h49;
  localparam logic [6:0] IDX_ONE = 7'h01;

  // header flag bits
  localparam int HDR_ALWAYS_BIT = 15;
  localparam int HDR_GEN_BIT = 10;
  localparam int HDR_PLANE_BIT = 8;
  localparam int HDR_AXIS_BIT = 0;

  // meaningful bits of the masked fields, the rest are forced to zero
  localparam logic [7:0] THREAD_MASK = 8'h3f;
  localparam logic [15:0] PLANE_STAT_MASK = 16'h8038;
  localparam logic [31:0] AMP_STAT_MASK = 32'h0101010f;
  localparam logic [7:0] AXIS_SW_MASK = 8'hcf;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  // velocity scale and torque limits
  localparam int VEL_SHIFT = 6;
  localparam logic signed [31:0] TORQUE_POS_MAX = 32'sh00007fff;
  localparam logic signed [31:0] TORQUE_NEG_MAX = -32'sh00007fff;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADDR_LAYOUT = 8'h10;
  localparam logic [7:0] ADDR_SAMPLE = 8'h14;

  // control bits
  localparam int CTRL_ONE_SHOT_BIT = 0;
  localparam int CTRL_OUTPUT_EN_BIT = 1;
  // state bits
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_PEND_BIT = 1;
  // interrupt bits
  localparam int INT_W = 2;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_SKIP_BIT = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [15:0] SAMPLE_ONE = 16'h0001;

  // one sample of controller status, raw from the controller core
  typedef struct packed {
    logic [15:0] gen_in;
    logic [15:0] gen_out;
    logic [7:0] err_code;
    logic [7:0] thread_run;
    logic [15:0] ain2;
    logic [15:0] aout1;
    logic [15:0] aout2;
    logic [31:0] amp_stat;
    logic [31:0] contour_seg;
    logic [15:0] contour_buf;
    logic [15:0] plane_seg;
    logic [15:0] plane_stat;
    logic [31:0] plane_dist;
    logic [15:0] plane_buf;
    logic [15:0] axis_stat;
    logic [7:0] axis_sw;
    logic [7:0] axis_stop;
    logic [31:0] ref_pos;
    logic [31:0] motor_pos;
    logic [31:0] pos_err;
    logic [31:0] aux_pos;
    logic [31:0] velocity;
    logic [31:0] torque;
    logic [15:0] ain1;
    logic [7:0] hall;
    logic [31:0] user_variable_field;
  } sra_sample_s;

  // outgoing record byte stream
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } sra_stream_s;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} sra_state_e;

endpackage : sra_pkg

// *** src/sra_packer.sv ***
/*
  sra_packer: lays one captured sample out as the binary record and picks one byte of it.
  assumes: the sample and sample number are held stable by the caller while bytes are read.
*/
`timescale 1ns/100ps
module sra_packer (
  // captured sample
  input wire sra_pkg::sra_sample_s smp,
  input wire logic [15:0] sample_num,
  // byte selection
  input wire logic [6:0] idx,
  output logic [7:0] byte_out
);

  logic [15:0] hdr_word;
  logic [7:0] thread_byte;
  logic [15:0] plane_stat;
  logic [31:0] amp_stat;
  logic [7:0] axis_sw;
  logic [31:0] vel_field;
  logic signed [31:0] torque_raw;
  logic [31:0] torque_field;
  logic [sra_pkg::REC_BITS-1:0] flat;
  logic [9:0] bit_pos;
  logic idx_in_range;

  // header flags, unused flag bits are zero
  assign hdr_word = (16'h0001 << sra_pkg::HDR_ALWAYS_BIT)
                  | (16'h0001 << sra_pkg::HDR_GEN_BIT)
                  | (16'h0001 << sra_pkg::HDR_PLANE_BIT)
                  | (16'h0001 << sra_pkg::HDR_AXIS_BIT);

  assign thread_byte = smp.thread_run & sra_pkg::THREAD_MASK;
  assign plane_stat = smp.plane_stat & sra_pkg::PLANE_STAT_MASK;
  assign amp_stat = smp.amp_stat & sra_pkg::AMP_STAT_MASK;
  assign axis_sw = smp.axis_sw & sra_pkg::AXIS_SW_MASK;

  // velocity field is 64 times the reported velocity
  assign vel_field = smp.velocity << sra_pkg::VEL_SHIFT;

  // torque limited to plus or minus full scale
  assign torque_raw = smp.torque;
  assign torque_field = (torque_raw > sra_pkg::TORQUE_POS_MAX) ? sra_pkg::TORQUE_POS_MAX :
                        (torque_raw < sra_pkg::TORQUE_NEG_MAX) ? sra_pkg::TORQUE_NEG_MAX :
                        torque_raw;

  // byte 0 in the low bits, every field little endian
  assign flat = {smp.user_variable_field,
                 sra_pkg::RESERVED_BYTE,
                 smp.hall,
                 smp.ain1,
                 torque_field,
                 vel_field,
                 smp.aux_pos,
                 smp.pos_err,
                 smp.motor_pos,
                 smp.ref_pos,
                 smp.axis_stop,
                 axis_sw,
                 smp.axis_stat,
                 smp.plane_buf,
                 smp.plane_dist,
                 plane_stat,
                 smp.plane_seg,
                 smp.contour_buf,
                 smp.contour_seg,
                 amp_stat,
                 smp.aout2,
                 smp.aout1,
                 smp.ain2,
                 thread_byte,
                 smp.err_code,
                 smp.gen_out,
                 smp.gen_in,
                 sample_num,
                 sra_pkg::REC_LEN,
                 hdr_word};

  // indices past the last byte read as zero instead of unknown
  assign bit_pos = {idx, 3'h0};
  assign idx_in_range = (idx <= sra_pkg::REC_LAST_IDX);
  assign byte_out = idx_in_range ? flat[bit_pos +: 8] : sra_pkg::RESERVED_BYTE;

endmodule : sra_packer

// *** src/sra_top.sv ***
/*
  sra_top: status record assembler with its AHB-Lite register slave and record byte stream.
  assumes: one 250 MHz clock hclk, async active-low hresetn, a single AHB-Lite master,
  and a status source that pulses sample_strobe with a full sample.
*/
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module sra_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // status source
  input wire logic sample_strobe,
  input wire sra_pkg::sra_sample_s sample,
  // record byte stream
  output logic rec_valid,
  output logic rec_last,
  output logic [7:0] rec_data,
  input wire logic rec_ready,
  // interrupt
  output logic irq
);

  sra_pkg::sra_state_e state_ff;
  sra_pkg::sra_state_e nxt_state;
  sra_pkg::sra_sample_s smp_ff;
  logic [15:0] sample_cnt_ff;
  logic [15:0] rec_sample_ff;
  logic [6:0] idx_ff;
  logic [6:0] nxt_idx;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic pend_ff;
  logic out_en_ff;
  logic [sra_pkg::INT_W-1:0] int_stat_ff;
  logic [sra_pkg::INT_W-1:0] int_mask_ff;
  logic wr_ph_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // bus decode
  logic addr_ok;
  logic wr_ctrl;
  logic wr_int_stat;
  logic wr_int_mask;
  logic one_shot_req;
  logic [sra_pkg::INT_W-1:0] int_clr;
  logic [31:0] ctrl_word;
  logic [31:0] state_word;
  logic [31:0] layout_word;

  // record engine
  logic want;
  logic idle;
  logic capture;
  logic skip;
  logic take;
  logic at_last;
  logic done;
  logic [sra_pkg::INT_W-1:0] int_ev;
  logic [6:0] pack_idx;
  logic [7:0] pack_byte;

  assign addr_ok = hsel & hready & (htrans == sra_pkg::HTRANS_NONSEQ);
  assign wr_ctrl = wr_ph_ff & (wr_addr_ff == sra_pkg::ADDR_CTRL);
  assign wr_int_stat = wr_ph_ff & (wr_addr_ff == sra_pkg::ADDR_INT_STAT);
  assign wr_int_mask = wr_ph_ff & (wr_addr_ff == sra_pkg::ADDR_INT_MASK);
  assign one_shot_req = wr_ctrl & hwdata[sra_pkg::CTRL_ONE_SHOT_BIT];
  assign int_clr = wr_int_stat ? hwdata[sra_pkg::INT_W-1:0] : '0;

  assign ctrl_word = {30'h0, out_en_ff, 1'b0};
  assign state_word = {30'h0, pend_ff, ~idle};
  assign layout_word = {sra_pkg::REC_AXIS_BYTES, sra_pkg::REC_PLANE_BYTES,
                        sra_pkg::REC_GEN_BYTES, sra_pkg::REC_AXES};

  // read data chosen in the address phase, unmapped reads give zero
  always_comb begin
    case (haddr)
      sra_pkg::ADDR_CTRL: nxt_rdata = ctrl_word;
      sra_pkg::ADDR_STATE: nxt_rdata = state_word;
      sra_pkg::ADDR_INT_STAT: nxt_rdata = {30'h0, int_stat_ff};
      sra_pkg::ADDR_INT_MASK: nxt_rdata = {30'h0, int_mask_ff};
      sra_pkg::ADDR_LAYOUT: nxt_rdata = layout_word;
      sra_pkg::ADDR_SAMPLE: nxt_rdata = {16'h0, sample_cnt_ff};
      default: nxt_rdata = sra_pkg::WORD_ZERO;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = sra_pkg::HRESP_OKAY;
  assign hrdata = rdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= sra_pkg::WORD_ZERO;
    end else if (hready) begin
      wr_ph_ff <= addr_ok & hwrite;
      wr_addr_ff <= haddr;
      rdata_ff <= (addr_ok & ~hwrite) ? nxt_rdata : sra_pkg::WORD_ZERO;
    end
  end

  // request logic: a one-shot query waits for the next sample, output mode takes every one that arrives while idle, one that arrives while busy is skipped
  assign idle = (state_ff == sra_pkg::ST_IDLE);
  assign want = pend_ff | out_en_ff;
  assign capture = sample_strobe & want & idle;
  assign skip = sample_strobe & want & ~idle;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
      out_en_ff <= 1'b0;
    end else begin
      pend_ff <= one_shot_req | (pend_ff & ~capture);
      if (wr_ctrl) begin
        out_en_ff <= hwdata[sra_pkg::CTRL_OUTPUT_EN_BIT];
      end
    end
  end

  // sample counter and capture of the whole sample at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_cnt_ff <= 16'h0000;
      rec_sample_ff <= 16'h0000;
      smp_ff <= '0;
    end else begin
      if (sample_strobe) begin
        sample_cnt_ff <= sample_cnt_ff + sra_pkg::SAMPLE_ONE;
      end
      if (capture) begin
        smp_ff <= sample;
        rec_sample_ff <= sample_cnt_ff;
      end
    end
  end

  // byte sequencer
  assign take = (state_ff == sra_pkg::ST_SEND) & rec_ready;
  assign at_last = (idx_ff == sra_pkg::REC_LAST_IDX);
  assign done = take & at_last;
  assign pack_idx = (state_ff == sra_pkg::ST_LOAD) ? idx_ff : idx_ff + sra_pkg::IDX_ONE;

  sra_packer u_packer (
    .smp(smp_ff),
    .sample_num(rec_sample_ff),
    .idx(pack_idx),
    .byte_out(pack_byte)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_data = data_ff;
    case (state_ff)
      sra_pkg::ST_IDLE: begin
        if (capture) begin
          nxt_state = sra_pkg::ST_LOAD;
          nxt_idx = 7'h00;
        end
      end
      sra_pkg::ST_LOAD: begin
        nxt_state = sra_pkg::ST_SEND;
        nxt_data = pack_byte;
      end
      sra_pkg::ST_SEND: begin
        if (done) begin
          nxt_state = sra_pkg::ST_IDLE;
        end else if (take) begin
          nxt_idx = pack_idx;
          nxt_data = pack_byte;
        end
      end
      default: begin
        nxt_state = sra_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= sra_pkg::ST_IDLE;
      idx_ff <= 7'h00;
      data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      data_ff <= nxt_data;
    end
  end

  assign rec_valid = (state_ff == sra_pkg::ST_SEND);
  assign rec_last = rec_valid & at_last;
  assign rec_data = data_ff;

  // sticky interrupt status, a new event wins over a clear in the same cycle
  assign int_ev = {skip, done};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= '0;
      int_mask_ff <= '0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_ev;
      if (wr_int_mask) begin
        int_mask_ff <= hwdata[sra_pkg::INT_W-1:0];
      end
    end
  end

  assign irq = |(int_stat_ff & int_mask_ff);

endmodule : sra_top

// *** test/sra_host_model.sv ***
/*
  sra_host_model: host side sink that takes record bytes, promptly or with stalls.
  assumes: one clock hclk, async active-low hresetn, slow chosen by the bench.
*/
`timescale 1ns/100ps
module sra_host_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // record stream
  input wire logic rec_valid,
  input wire logic rec_last,
  input wire logic [7:0] rec_data,
  output logic rec_ready,
  // pacing
  input wire logic slow
);
  logic [7:0] got[$];
  int recs;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_ready <= 1'b0;
      recs = 0;
    end else begin
      // slow mode stalls every other cycle
      rec_ready <= slow ? ~rec_ready : 1'b1;
      if (rec_valid && rec_ready) begin
        got.push_back(rec_data);
        if (rec_last) recs = recs + 1;
      end
    end
  end
endmodule : sra_host_model

// *** test/sra_top_asserts.sv ***
/*
  sra_top_asserts: concurrent checks on the ports of sra_top.
  assumes: bound into sra_top, single clock hclk, async active-low hresetn.
*/
`timescale 1ns/100ps
module sra_top_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // stream
  input wire logic rec_valid,
  input wire logic rec_last,
  input wire logic [7:0] rec_data,
  input wire logic rec_ready
);
  logic [6:0] cnt_ff;
  logic rd_ff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // byte position and read data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 7'h00;
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= hsel && hready && htrans == 2'h2 && !hwrite;
      if (rec_valid && rec_ready) cnt_ff <= rec_last ? 7'h00 : cnt_ff + 7'h01;
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  rd_zero_a: assert property (!rd_ff |-> hrdata == 32'h0) else $error("hrdata not zero");
  hold_byte_a: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("byte not held");
  first_byte_a: assert property ($rose(rec_valid) |-> rec_data == 8'h01)
    else $error("bad header byte 0");
  hdr_bytes_a: assert property (rec_valid && cnt_ff == 7'h01 |-> rec_data == 8'h85)
    else $error("bad header byte 1");
  len_bytes_a: assert property (rec_valid && cnt_ff == 7'h02 |-> rec_data == 8'h4a)
    else $error("bad length byte");
  last_pos_a: assert property (rec_valid |-> rec_last == (cnt_ff == 7'h49))
    else $error("last flag misplaced");
  end_gap_a: assert property (rec_valid && rec_ready && rec_last |=> !rec_valid)
    else $error("stream runs past last");
  rsvd_zero_a: assert property (rec_valid && cnt_ff == 7'h45 |-> rec_data == 8'h00)
    else $error("reserved byte not zero");
  thread_bits_a: assert property (rec_valid && cnt_ff == 7'h0b |-> rec_data[7:6] == 2'h0)
    else $error("thread spare bits set");
  plane_bits_a: assert property (rec_valid && cnt_ff == 7'h1f |-> rec_data[6:0] == 7'h0)
    else $error("plane status spare bits set");
endmodule : sra_top_asserts
bind sra_top sra_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hready(hready), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rec_valid(rec_valid), .rec_last(rec_last), .rec_data(rec_data),
  .rec_ready(rec_ready));

// *** test/tb_top.sv ***
/*
  tb_top: self-checking bench of sra_top with an AHB-Lite master and a host sink.
  assumes: sra_pkg, sra_top and sra_host_model compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, sample_strobe, slow, irq, rec_valid, rec_last, rec_ready;
  logic hreadyout, hresp;
  logic [7:0] haddr, rec_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  sra_pkg::sra_sample_s sample;
  logic [7:0] exp_q[$];
  int fails, samples_checked;
  wire hready = hreadyout;
  sra_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sample_strobe(sample_strobe), .sample(sample),
    .rec_valid(rec_valid), .rec_last(rec_last), .rec_data(rec_data), .rec_ready(rec_ready),
    .irq(irq));
  sra_host_model host (.hclk(hclk), .hresetn(hresetn), .rec_valid(rec_valid),
    .rec_last(rec_last), .rec_data(rec_data), .rec_ready(rec_ready), .slow(slow));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= sra_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic put(input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(v[i*8+:8]);
  endtask : put
  // expected record from the sample fields
  task automatic build(input sra_pkg::sra_sample_s s, input logic [15:0] n);
    logic [31:0] t;
    t = s.torque;
    if ($signed(t) > 32767) t = 32'h00007fff;
    if ($signed(t) < -32767) t = 32'hffff8001;
    exp_q.delete();
    put(32'h004a8501, 4); put(n, 2); put(s.gen_in, 2); put(s.gen_out, 2); put(s.err_code, 1);
    put(s.thread_run & 8'h3f, 1); put(s.ain2, 2); put(s.aout1, 2); put(s.aout2, 2);
    put(s.amp_stat & 32'h0101010f, 4); put(s.contour_seg, 4); put(s.contour_buf, 2);
    put(s.plane_seg, 2); put(s.plane_stat & 16'h8038, 2); put(s.plane_dist, 4);
    put(s.plane_buf, 2); put(s.axis_stat, 2); put(s.axis_sw & 8'hcf, 1); put(s.axis_stop, 1);
    put(s.ref_pos, 4); put(s.motor_pos, 4); put(s.pos_err, 4); put(s.aux_pos, 4);
    put(s.velocity << 6, 4); put(t, 4); put(s.ain1, 2); put(s.hall, 1); put(32'h0, 1);
    put(s.user_variable_field, 4);
  endtask : build
  task automatic strobe(input logic [7:0] k, input logic [31:0] tq);
    sra_pkg::sra_sample_s v;
    for (int i = 0; i < $bits(v) / 8; i++) v[i*8+:8] = k + 8'(i * 37);
    v.torque = tq;
    @(posedge hclk);
    sample <= v;
    sample_strobe <= 1'b1;
    @(posedge hclk);
    sample_strobe <= 1'b0;
  endtask : strobe
  task automatic take_rec(input int n);
    for (int i = 0; i < 400 && host.recs < n; i++) @(negedge hclk);
    chk(host.got.size(), 74, "record length");
    for (int i = 0; i < 74 && i < host.got.size(); i++) chk(host.got[i], exp_q[i], "byte");
    host.got.delete();
  endtask : take_rec
  task automatic t_regs;
    ahb(sra_pkg::ADDR_LAYOUT, 1'b0, 32'h0); chk(r, 32'h24101201, "layout");
    ahb(8'h18, 1'b1, 32'hffffffff); ahb(8'h18, 1'b0, 32'h0); chk(r, 32'h0, "unmapped");
    ahb(sra_pkg::ADDR_STATE, 1'b0, 32'h0); chk(r, 32'h0, "state");
    $display("test regs done");
  endtask : t_regs
  task automatic t_one_shot;
    ahb(sra_pkg::ADDR_INT_MASK, 1'b1, 32'h3);
    ahb(sra_pkg::ADDR_CTRL, 1'b1, 32'h1);
    ahb(sra_pkg::ADDR_CTRL, 1'b0, 32'h0); chk(r, 32'h0, "one-shot self clears");
    ahb(sra_pkg::ADDR_STATE, 1'b0, 32'h0); chk(r, 32'h2, "query pending");
    strobe(8'h11, 32'h00012345);
    build(sample, 16'h0000);
    take_rec(1);
    chk(irq, 1'b1, "irq after record");
    ahb(sra_pkg::ADDR_INT_STAT, 1'b1, 32'h1);
    @(negedge hclk);
    chk(irq, 1'b0, "irq cleared");
    strobe(8'h22, 32'h0);
    repeat (100) @(posedge hclk);
    chk(host.got.size(), 0, "no record without request");
    ahb(sra_pkg::ADDR_SAMPLE, 1'b0, 32'h0); chk(r, 32'h2, "sample counter");
    $display("test one shot done");
  endtask : t_one_shot
  task automatic t_output;
    slow <= 1'b1;
    ahb(sra_pkg::ADDR_CTRL, 1'b1, 32'h2);
    strobe(8'h5c, 32'hfffe0000);
    build(sample, 16'h0002);
    repeat (6) @(posedge hclk);
    strobe(8'h33, 32'h0);
    ahb(sra_pkg::ADDR_STATE, 1'b0, 32'h0); chk(r, 32'h1, "busy in record");
    take_rec(2);
    ahb(sra_pkg::ADDR_CTRL, 1'b1, 32'h0);
    ahb(sra_pkg::ADDR_INT_STAT, 1'b0, 32'h0); chk(r, 32'h3, "done and skip");
    ahb(sra_pkg::ADDR_INT_MASK, 1'b0, 32'h0); chk(r, 32'h3, "mask readback");
    ahb(sra_pkg::ADDR_INT_STAT, 1'b1, 32'h1);
    @(negedge hclk);
    chk(irq, 1'b1, "irq held by skip");
    ahb(sra_pkg::ADDR_INT_STAT, 1'b1, 32'h2);
    @(negedge hclk);
    chk(irq, 1'b0, "irq cleared");
    slow <= 1'b0;
    $display("test output done");
  endtask : t_output
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #40000;
    fails++;
    summarize();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; sample_strobe = 1'b0; sample = '0; slow = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_one_shot();
    t_output();
    summarize();
  end
endmodule : tb_top
